// [pkg/level_detect_pkg.sv]
// constants and types for the dual level detector
// Behaviour
// - timer starts when magnitude reaches threshold
// - below threshold clears timer and output
// - output active after full delay elapses
// - detector one delay 0-300.0 s, default 10.0
// - detector two delay independent, same range
// - detector one source default speed feedback
// - detector two source default ramp input
// - detector one limit 0.1-100%, default 10%
// - current source sets limit ceiling to current ceiling
// - detector two limit same, default 10%
// - current ceiling 25-200%, default 150%
package level_detect_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DELAY_ONE   = 8'h00;
    localparam logic [7:0] OFS_DELAY_TWO   = 8'h04;
    localparam logic [7:0] OFS_SELECT_ONE  = 8'h08;
    localparam logic [7:0] OFS_SELECT_TWO  = 8'h0C;
    localparam logic [7:0] OFS_LIMIT_ONE   = 8'h10;
    localparam logic [7:0] OFS_LIMIT_TWO   = 8'h14;
    localparam logic [7:0] OFS_CEILING     = 8'h18;
    localparam logic [7:0] OFS_STATUS      = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h24;
    // delay in tenths of a second
    localparam logic [11:0] DELAY_MAX      = 12'hBB8; // 300.0 s
    localparam logic [11:0] DELAY_RESET    = 12'h064; // 10.0 s
    // limits in tenths of a percent of full scale
    localparam logic [11:0] LIMIT_MIN      = 12'h001; // 0.1 %
    localparam logic [11:0] LIMIT_FULL     = 12'h3E8; // 100.0 %
    localparam logic [11:0] LIMIT_RESET    = 12'h064; // 10.0 %
    // current ceiling in whole percent of rated_armature_current
    localparam logic [7:0]  CEIL_MIN       = 8'h19;   // 25 %
    localparam logic [7:0]  CEIL_MAX       = 8'hC8;   // 200 %
    localparam logic [7:0]  CEIL_RESET     = 8'h96;   // 150 %
    // tick timing
    localparam int          CLK_HZ         = 125_000_000;
    localparam int          TICK_MS        = 100;
    localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    // source choices
    typedef enum logic [2:0] {
        SRC_SPEED_SOURCE = 3'h0,
        SRC_RAMP_INPUT   = 3'h1,
        SRC_RAMP_OUTPUT  = 3'h2,
        SRC_SPEED_FB     = 3'h3,
        SRC_CURRENT_FB   = 3'h4
    } source_t;
endpackage

// [rtl/dual_level_detector.sv]
// two level detectors with apb registers and interrupt
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dual_level_detector #(
    parameter int TICK_CYCLES_P = level_detect_pkg::TICK_CYCLES,
    parameter int SIG_W         = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [SIG_W-1:0]  speed_source_out,
    input  wire logic [SIG_W-1:0]  ramp_input_signal,
    input  wire logic [SIG_W-1:0]  ramp_output_signal,
    input  wire logic [SIG_W-1:0]  speed_loop_feedback,
    input  wire logic [SIG_W-1:0]  current_loop_feedback,
    output logic                   detect_one,
    output logic                   detect_two,
    output logic                   irq
);
    import level_detect_pkg::*;

    // every assertion below runs on pclk and sleeps while reset is low
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // magnitude of a signed sample, saturating the most negative code
    function automatic logic [SIG_W-1:0] magnitude(input logic [SIG_W-1:0] v);
        logic [SIG_W-1:0] n;
        n = -v;
        if (!v[SIG_W-1])
            magnitude = v;
        else if (n[SIG_W-1])
            magnitude = {1'b0, {(SIG_W-1){1'b1}}};
        else
            magnitude = n;
    endfunction

    // limit in tenths of percent scaled to signal units; full scale is the
    // positive maximum, current full scale is the ceiling
    function automatic logic [SIG_W-1:0] scale(input logic [11:0] lim,
                                               input logic [7:0] ceil,
                                               input logic is_cur);
        logic [SIG_W+23:0] p;
        p = '0;
        if (is_cur)
            p = (SIG_W+24)'(lim) * (SIG_W+24)'({(SIG_W-1){1'b1}})
                / ((SIG_W+24)'(ceil) * (SIG_W+24)'(10));
        else
            p = (SIG_W+24)'(lim) * (SIG_W+24)'({(SIG_W-1){1'b1}})
                / (SIG_W+24)'(LIMIT_FULL);
        scale = p[SIG_W-1:0];
    endfunction

    // clamp a limit write into its legal range
    function automatic logic [11:0] clamp_limit(input logic [11:0] v,
                                                input logic [11:0] top);
        if (v < LIMIT_MIN)
            clamp_limit = LIMIT_MIN;
        else if (v > top)
            clamp_limit = top;
        else
            clamp_limit = v;
    endfunction

    function automatic logic [11:0] clamp_delay(input logic [11:0] v);
        clamp_delay = (v > DELAY_MAX) ? DELAY_MAX : v;
    endfunction

    // highest legal limit in tenths of percent: ten times the ceiling
    // under current feedback, full scale for every other source
    function automatic logic [11:0] limit_top(input logic [2:0] s,
                                              input logic [7:0] ceil);
        if (s == SRC_CURRENT_FB)
            limit_top = {1'b0, ceil, 3'h0} + {3'h0, ceil, 1'b0};
        else
            limit_top = LIMIT_FULL;
    endfunction

    function automatic logic [SIG_W-1:0] pick(input logic [2:0] s,
        input logic [SIG_W-1:0] a, input logic [SIG_W-1:0] b,
        input logic [SIG_W-1:0] c, input logic [SIG_W-1:0] d,
        input logic [SIG_W-1:0] e);
        case (s)
            SRC_SPEED_SOURCE: pick = a;
            SRC_RAMP_INPUT:   pick = b;
            SRC_RAMP_OUTPUT:  pick = c;
            SRC_SPEED_FB:     pick = d;
            default:          pick = e;
        endcase
    endfunction

    logic [11:0] delay_one_q, delay_two_q, limit_one_q, limit_two_q;
    logic [2:0]  select_one_q, select_two_q;
    logic [7:0]  ceiling_q;
    logic [1:0]  irq_status_q, irq_mask_q;
    logic [11:0] timer_one_q, timer_two_q;
    logic        detect_one_q, detect_two_q;
    logic [31:0] tick_cnt_q;
    logic        tick_q;

    // bus decode: zero wait states, unmapped addresses answer with error
    wire         access    = psel && penable;
    wire         wr        = access && pwrite;
    wire         mapped    = (paddr <= OFS_IRQ_MASK) && (paddr[1:0] == 2'b00);
    // oversized writes saturate, so dropped upper bits never wrap a value
    wire [11:0]  wr12      = (|pwdata[31:12]) ? 12'hFFF : pwdata[11:0];
    wire [7:0]   wr8       = (|pwdata[31:8]) ? 8'hFF : pwdata[7:0];
    wire [11:0]  top_one   = limit_top(select_one_q, ceiling_q);
    wire [11:0]  top_two   = limit_top(select_two_q, ceiling_q);
    // a select code above the last source is ignored, upper bits included
    wire         sel_ok1   = ~|pwdata[31:3] && (pwdata[2:0] <= SRC_CURRENT_FB);
    wire         sel_ok2   = sel_ok1;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign irq     = |(irq_status_q & irq_mask_q);
    assign detect_one = detect_one_q;
    assign detect_two = detect_two_q;

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            OFS_DELAY_ONE:  prdata[11:0] = delay_one_q;
            OFS_DELAY_TWO:  prdata[11:0] = delay_two_q;
            OFS_SELECT_ONE: prdata[2:0]  = select_one_q;
            OFS_SELECT_TWO: prdata[2:0]  = select_two_q;
            OFS_LIMIT_ONE:  prdata[11:0] = limit_one_q;
            OFS_LIMIT_TWO:  prdata[11:0] = limit_two_q;
            OFS_CEILING:    prdata[7:0]  = ceiling_q;
            OFS_STATUS:     prdata[1:0]  = {detect_two_q, detect_one_q};
            OFS_IRQ_STATUS: prdata[1:0]  = irq_status_q;
            OFS_IRQ_MASK:   prdata[1:0]  = irq_mask_q;
            default:        prdata = 32'h0000_0000;
        endcase
    end

    // settings; limits re-clamped when source or ceiling shrink the range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_one_q  <= DELAY_RESET;
            delay_two_q  <= DELAY_RESET;
            select_one_q <= SRC_SPEED_FB;
            select_two_q <= SRC_RAMP_INPUT;
            limit_one_q  <= LIMIT_RESET;
            limit_two_q  <= LIMIT_RESET;
            ceiling_q    <= CEIL_RESET;
            irq_mask_q   <= 2'h0;
        end else begin
            if (wr && paddr == OFS_DELAY_ONE) delay_one_q <= clamp_delay(wr12);
            if (wr && paddr == OFS_DELAY_TWO) delay_two_q <= clamp_delay(wr12);
            if (wr && paddr == OFS_SELECT_ONE && sel_ok1)
                select_one_q <= wr8[2:0];
            if (wr && paddr == OFS_SELECT_TWO && sel_ok2)
                select_two_q <= wr8[2:0];
            if (wr && paddr == OFS_LIMIT_ONE)
                limit_one_q <= clamp_limit(wr12, top_one);
            else
                limit_one_q <= clamp_limit(limit_one_q, top_one);
            if (wr && paddr == OFS_LIMIT_TWO)
                limit_two_q <= clamp_limit(wr12, top_two);
            else
                limit_two_q <= clamp_limit(limit_two_q, top_two);
            if (wr && paddr == OFS_CEILING)
                ceiling_q <= (wr8 < CEIL_MIN) ? CEIL_MIN
                           : (wr8 > CEIL_MAX) ? CEIL_MAX : wr8;
            if (wr && paddr == OFS_IRQ_MASK) irq_mask_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= (tick_cnt_q == 32'(TICK_CYCLES_P - 1));
            tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES_P - 1))
                          ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        end
    end

    // comparison happens every clock, so a drop clears at once
    wire [SIG_W-1:0] mag_one = magnitude(pick(select_one_q, speed_source_out,
        ramp_input_signal, ramp_output_signal, speed_loop_feedback,
        current_loop_feedback));
    wire [SIG_W-1:0] mag_two = magnitude(pick(select_two_q, speed_source_out,
        ramp_input_signal, ramp_output_signal, speed_loop_feedback,
        current_loop_feedback));
    wire [SIG_W-1:0] thr_one = scale(limit_one_q, ceiling_q,
                                     select_one_q == SRC_CURRENT_FB);
    wire [SIG_W-1:0] thr_two = scale(limit_two_q, ceiling_q,
                                     select_two_q == SRC_CURRENT_FB);
    wire             met_one = mag_one >= thr_one;
    wire             met_two = mag_two >= thr_two;
    wire             done_one = timer_one_q >= delay_one_q;
    wire             done_two = timer_two_q >= delay_two_q;
    wire             rise_one = met_one && done_one && !detect_one_q;
    wire             rise_two = met_two && done_two && !detect_two_q;

    // timers and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_q  <= 12'h000;
            timer_two_q  <= 12'h000;
            detect_one_q <= 1'b0;
            detect_two_q <= 1'b0;
        end else begin
            if (!met_one) timer_one_q <= 12'h000;
            else if (tick_q && !done_one) timer_one_q <= timer_one_q + 12'h001;
            if (!met_two) timer_two_q <= 12'h000;
            else if (tick_q && !done_two) timer_two_q <= timer_two_q + 12'h001;
            detect_one_q <= met_one && done_one;
            detect_two_q <= met_two && done_two;
        end
    end

    // sticky events on output rising; set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_status_q <= 2'h0;
        else
            irq_status_q <= (irq_status_q
                & ~((wr && paddr == OFS_IRQ_STATUS) ? pwdata[1:0] : 2'h0))
                | {rise_two, rise_one};
    end

    // a detector whose level has stood for the whole delay
    sequence elapsed_one_s;
        met_one && done_one;
    endsequence
    sequence elapsed_two_s;
        met_two && done_two;
    endsequence

    drop_clears_a: assert property (
        !met_one |=> !detect_one_q && timer_one_q == 12'h000)
        else $error("detector one not cleared after drop");
    drop_two_a: assert property (
        !met_two |=> !detect_two_q && timer_two_q == 12'h000)
        else $error("detector two not cleared after drop");
    output_delay_a: assert property (
        $rose(detect_one_q) |-> $past(timer_one_q) >= $past(delay_one_q))
        else $error("detector one rose early");
    // elapsed delay raises the output one cycle later
    rise_one_a: assert property (elapsed_one_s |=> detect_one_q)
        else $error("detector one missed its delay");
    rise_two_a: assert property (elapsed_two_s |=> detect_two_q)
        else $error("detector two missed its delay");
    // timer holds at zero while below
    timer_start_a: assert property (
        timer_two_q != 12'h000 |-> $past(met_two))
        else $error("detector two timer ran below limit");
    // a met level advances the timer on each tick until the delay is reached
    timer_runs_a: assert property (
        met_one && tick_q && !done_one
        |=> timer_one_q == $past(timer_one_q) + 12'h001)
        else $error("detector one timer missed a tick");
    delay_range_a: assert property (
        delay_one_q <= DELAY_MAX && delay_two_q <= DELAY_MAX)
        else $error("delay out of range");
    ceil_range_a: assert property (
        ceiling_q >= CEIL_MIN && ceiling_q <= CEIL_MAX)
        else $error("ceiling out of range");
    // full scale bounds limit one once current is left
    limit_range_a: assert property (
        $past(select_one_q) != SRC_CURRENT_FB |-> limit_one_q <= LIMIT_FULL)
        else $error("limit one above full scale");
    // no limit ever passes ten times the largest ceiling
    limit_cur_a: assert property (
        limit_one_q <= 12'(CEIL_MAX) * 12'h00A
        && limit_two_q <= 12'(CEIL_MAX) * 12'h00A)
        else $error("limit above current ceiling");
    // limit two never under its minimum
    limit_two_a: assert property (
        limit_two_q >= LIMIT_MIN)
        else $error("limit two below minimum");
    // tick is a single cycle pulse
    tick_gap_a: assert property (
        tick_q |=> !tick_q)
        else $error("tick lasted two cycles");
    // a rise sets its sticky bit even when a clear lands with it
    set_wins_a: assert property (
        rise_one |=> irq_status_q[0])
        else $error("rise lost its sticky bit");
endmodule // dual_level_detector
`default_nettype wire

// [test/drive_signal_model.sv]
// behavioural source of the five internal drive levels
`timescale 1ns/1ns
`default_nettype none
module drive_signal_model #(
    parameter int SIG_W = 16
) (
    input  wire logic             pclk,
    output logic [SIG_W-1:0] speed_source_out,
    output logic [SIG_W-1:0] ramp_input_signal,
    output logic [SIG_W-1:0] ramp_output_signal,
    output logic [SIG_W-1:0] speed_loop_feedback,
    output logic [SIG_W-1:0] current_loop_feedback
);
    logic [SIG_W-1:0] lvl_q [5];

    // levels start at zero so no detector is met after reset
    initial begin
        foreach (lvl_q[i]) lvl_q[i] = '0;
    end

    // index follows the select codes of the detectors
    assign speed_source_out      = lvl_q[0];
    assign ramp_input_signal     = lvl_q[1];
    assign ramp_output_signal    = lvl_q[2];
    assign speed_loop_feedback   = lvl_q[3];
    assign current_loop_feedback = lvl_q[4];

    // a level moves just after a rising edge, like regulator output
    task automatic set_level(input int idx, input logic [SIG_W-1:0] v);
        @(posedge pclk);
        lvl_q[idx] <= v;
    endtask
endmodule // drive_signal_model
`default_nettype wire

// [test/dual_level_detector_tb.sv]
// register and detection test of the dual level detector
`timescale 1ns/1ns
`default_nettype none
module dual_level_detector_tb;
    import level_detect_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] s0, s1, s2, s3, s4;
    logic        detect_one, detect_two, irq;
    int          err_total, checked, n;

    dual_level_detector #(.TICK_CYCLES_P(10), .SIG_W(16))
        u_dual_level_detector (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speed_source_out(s0),
        .ramp_input_signal(s1), .ramp_output_signal(s2),
        .speed_loop_feedback(s3), .current_loop_feedback(s4),
        .detect_one(detect_one), .detect_two(detect_two), .irq(irq));
    drive_signal_model #(.SIG_W(16)) u_drive_signal_model (
        .pclk(pclk), .speed_source_out(s0), .ramp_input_signal(s1),
        .ramp_output_signal(s2), .speed_loop_feedback(s3),
        .current_loop_feedback(s4));

    // clock of 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, then one idle edge so that register effects
    // have settled and no strobe is driven twice in one time step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_total++;
            $display("mismatch pready expected 1 seen %b", pready);
            conclude();
        end else begin
            rd = prdata;
            rerr = pslverr;
            psel <= 1'b0; penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // counts edges until a detector output reaches lvl, bounded
    task automatic wait_det(input bit two, input logic lvl, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((two ? detect_two : detect_one) !== lvl && n < lim);
    endtask

    // hang guard far above the run time of the test
    initial begin
        #400000;
        err_total++;
        conclude();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; err_total = 0; checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("delay1", OFS_DELAY_ONE, 32'h64);
        rchk("delay2", OFS_DELAY_TWO, 32'h64);
        rchk("sel1", OFS_SELECT_ONE, 32'h3);
        rchk("sel2", OFS_SELECT_TWO, 32'h1);
        rchk("limit1", OFS_LIMIT_ONE, 32'h64);
        rchk("limit2", OFS_LIMIT_TWO, 32'h64);
        rchk("ceiling", OFS_CEILING, 32'h96);
        rchk("mask", OFS_IRQ_MASK, 32'h0);
        // clamping at delay one maximum and both ends of ceiling and limit one; bad select ignored
        apb(1'b1, OFS_DELAY_ONE, 32'hBB9);
        rchk("delay1 max", OFS_DELAY_ONE, 32'hBB8);
        apb(1'b1, OFS_CEILING, 32'h0A);
        rchk("ceiling min", OFS_CEILING, 32'h19);
        apb(1'b1, OFS_CEILING, 32'hFA);
        rchk("ceiling max", OFS_CEILING, 32'hC8);
        apb(1'b1, OFS_LIMIT_ONE, 32'h0);
        rchk("limit1 min", OFS_LIMIT_ONE, 32'h1);
        apb(1'b1, OFS_LIMIT_ONE, 32'h7D0);
        rchk("limit1 top", OFS_LIMIT_ONE, 32'h3E8);
        apb(1'b1, OFS_SELECT_ONE, 32'h5);
        rchk("sel1 bad", OFS_SELECT_ONE, 32'h3);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rd);
        // every source code is accepted by detector two
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, OFS_SELECT_TWO, c);
            rchk("sel2 code", OFS_SELECT_TWO, c);
        end
        // current source: limit top follows the ceiling
        apb(1'b1, OFS_SELECT_ONE, 32'h4);
        apb(1'b1, OFS_LIMIT_ONE, 32'h7D0);
        rchk("limit1 cur", OFS_LIMIT_ONE, 32'h7D0);
        apb(1'b1, OFS_CEILING, 32'h32);
        rchk("limit1 shrink", OFS_LIMIT_ONE, 32'h1F4);
        // detector one: half scale, 0.3 s, negative level
        apb(1'b1, OFS_SELECT_ONE, 32'h0);
        apb(1'b1, OFS_LIMIT_ONE, 32'h1F4);
        apb(1'b1, OFS_DELAY_ONE, 32'h3);
        u_drive_signal_model.set_level(0, 16'hB1E0);
        wait_det(1'b0, 1'b1, 100);
        chk("det1 delay", 32'h1, (n >= 21 && n <= 33));
        chk("irq masked", 32'h0, {31'h0, irq});
        u_drive_signal_model.set_level(0, 16'h0064);
        wait_det(1'b0, 1'b0, 2);
        chk("det1 drop", 32'h0, {31'h0, detect_one});
        // detector two alone with zero delay
        apb(1'b1, OFS_SELECT_TWO, 32'h2);
        apb(1'b1, OFS_DELAY_TWO, 32'h0);
        u_drive_signal_model.set_level(2, 16'h1000);
        wait_det(1'b1, 1'b1, 3);
        chk("det2 zero", 32'h1, (n <= 2));
        chk("det1 idle", 32'h0, {31'h0, detect_one});
        rchk("status", OFS_STATUS, 32'h2);
        rchk("irq status", OFS_IRQ_STATUS, 32'h3);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        chk("irq off", 32'h0, {31'h0, irq});
        rchk("irq left", OFS_IRQ_STATUS, 32'h2);
        // current source: threshold scales to the 50 % ceiling
        apb(1'b1, OFS_SELECT_TWO, 32'h4);
        u_drive_signal_model.set_level(4, 16'h1000);
        wait_det(1'b1, 1'b1, 3);
        chk("det2 cur low", 32'h0, {31'h0, detect_two});
        u_drive_signal_model.set_level(4, 16'h2000);
        wait_det(1'b1, 1'b1, 3);
        chk("det2 cur high", 32'h1, {31'h0, detect_two});
        conclude();
    end
endmodule // dual_level_detector_tb
`default_nettype wire
